// *** rtl/tsic_consts.svh ***
/*
 * Constants of the twelve-source interrupt controller: register map,
 * field positions, reset values and machine-cycle timing.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef TSIC_CONSTS_SVH
`define TSIC_CONSTS_SVH
`define TSIC_NSRC 12
`define TSIC_NFLAG 15
`define TSIC_NPIN 6
`define TSIC_PIN_IDLE 6'h3F
`define TSIC_PH_C3 2'h2
`define TSIC_MC_CLKS 4
`define TSIC_CALL_MCS 4
`define TSIC_CALL_LAST 5'(`TSIC_CALL_MCS * `TSIC_MC_CLKS - 1)
`define TSIC_OFF_EN 8'h00
`define TSIC_OFF_PRI 8'h04
`define TSIC_OFF_FLAG 8'h08
`define TSIC_OFF_CFG 8'h0C
`define TSIC_OFF_STAT 8'h10
`define TSIC_EN_GLOBAL 12
`define TSIC_F_EXT0 0
`define TSIC_F_TF0 1
`define TSIC_F_EXT1 2
`define TSIC_F_TF1 3
`define TSIC_F_RI0 4
`define TSIC_F_TI0 5
`define TSIC_F_TF2 6
`define TSIC_F_TIMER2_CAPTURE_RELOAD_FLAG 7
`define TSIC_F_RI1 8
`define TSIC_F_TI1 9
`define TSIC_F_EXT2 10
`define TSIC_F_EXT5 13
`define TSIC_F_WATCHDOG_REQUEST_FLAG 14
`define TSIC_C_TRIG0 0
`define TSIC_C_TRIG1 1
`define TSIC_C_HC2 2
`define TSIC_C_PFEN 6
`define TSIC_S_EXT0 4'h0
`define TSIC_S_TF0 4'h1
`define TSIC_S_EXT1 4'h2
`define TSIC_S_TF1 4'h3
`define TSIC_S_EXT2 4'h7
`define TSIC_S_EXT5 4'hA
`define TSIC_VEC_BASE 16'h0003
`define TSIC_VEC_STEP 16'h0008
`define TSIC_VEC_GAP 4'h6
`define TSIC_RST_REG 32'h00000000
`endif

// *** rtl/tsic_pkg.sv ***
/*
 * Types and the vector decode of the interrupt controller.
 * Assumes the constants header is on the include path.
 */
`include "tsic_consts.svh"
package tsic_pkg;
    typedef logic [3:0] tsic_src_t;
    typedef logic [`TSIC_NSRC-1:0] tsic_mask_t;
    typedef logic [15:0] tsic_vec_t;
    typedef enum logic {TSIC_IDLE, TSIC_CALL} tsic_call_e;

    // Slot 6 is unused between timer 2 and serial 1
    function automatic tsic_vec_t tsic_vector(tsic_src_t idx);
        tsic_src_t slot;
        slot = (idx < `TSIC_VEC_GAP) ? idx : tsic_src_t'(idx + 4'h1);
        return 16'(`TSIC_VEC_BASE + `TSIC_VEC_STEP * 16'(slot));
    endfunction
endpackage

// *** rtl/tsic_res_if.sv ***
/*
 * Carrier between the controller core and its priority resolver.
 * Assumes both ends run on the same clock; contents are combinational.
 */
`timescale 1ns/10ps
interface tsic_res_if;
    import tsic_pkg::*;
    tsic_mask_t req;
    tsic_mask_t hi;
    logic [1:0] in_svc;
    logic grant;
    logic win_hi;
    tsic_src_t win;
    modport ctl (output req, hi, in_svc, input grant, win_hi, win);
    modport res (input req, hi, in_svc, output grant, win_hi, win);
endinterface

// *** rtl/tsic_resolver.sv ***
/*
 * Priority resolver: picks the winning source and checks preemption.
 * Assumes requests are already gated by the enables.
 */
`timescale 1ns/10ps
`include "tsic_consts.svh"
module tsic_resolver (
    tsic_res_if.res rif
);
    import tsic_pkg::*;

    // Lowest index wins a tie
    function automatic tsic_src_t first_set(tsic_mask_t m);
        tsic_src_t r;
        r = '0;
        for (int i = `TSIC_NSRC - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = tsic_src_t'(i);
            end
        end
        return r;
    endfunction

    tsic_mask_t hi_req;
    tsic_mask_t lo_req;

    always_comb begin
        hi_req = rif.req & rif.hi;
        lo_req = rif.req & ~rif.hi;
        if (|hi_req) begin
            rif.win = first_set(hi_req);
            rif.win_hi = 1'b1;
            rif.grant = ~rif.in_svc[1];
        end else begin
            rif.win = first_set(lo_req);
            rif.win_hi = 1'b0;
            rif.grant = |lo_req & ~|rif.in_svc;
        end
    end
endmodule

// *** rtl/tsic_pin_sampler.sv ***
/*
 * External request pin sampler: three-stage synchroniser, agreement
 * filter and a per-machine-cycle sample for falling-edge detection.
 * Assumes sample_i pulses once per machine cycle at phase C3.
 */
`timescale 1ns/10ps
`include "tsic_consts.svh"
module tsic_pin_sampler (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [`TSIC_NPIN-1:0] pin_i,
    input wire logic sample_i,
    output logic [`TSIC_NPIN-1:0] fall_o,
    output logic [`TSIC_NPIN-1:0] low_o
);
    logic [`TSIC_NPIN-1:0] s1, s2, s3, stable, samp;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1 <= `TSIC_PIN_IDLE;
            s2 <= `TSIC_PIN_IDLE;
            s3 <= `TSIC_PIN_IDLE;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Take a bit only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stable <= `TSIC_PIN_IDLE;
        end else begin
            stable <= (s2 & ~(s2 ^ s3)) | (stable & (s2 ^ s3));
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            samp <= `TSIC_PIN_IDLE;
        end else if (sample_i) begin
            samp <= stable;
        end
    end

    assign fall_o = {`TSIC_NPIN{sample_i}} & samp & ~stable;
    assign low_o = ~stable;
endmodule

// *** rtl/tsic_top.sv ***
/*
 * Twelve-source interrupt controller with APB register access.
 * Holds flags, enables, priorities and the in-service state, and
 * drives the hardware call towards the core sequencer.
 * Assumes the core flags the last cycle of each instruction and any
 * instruction that writes enables or priorities or returns.
 */
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "tsic_consts.svh"
module tsic_top (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [`TSIC_NPIN-1:0] ext_request_pin_i,
    input wire logic timer0_overflow_i,
    input wire logic timer1_overflow_i,
    input wire logic timer2_overflow_i,
    input wire logic timer2_capture_reload_i,
    input wire logic watchdog_timeout_i,
    input wire logic serial0_rx_done_i,
    input wire logic serial0_tx_done_i,
    input wire logic serial1_rx_done_i,
    input wire logic serial1_tx_done_i,
    input wire logic power_fail_i,
    input wire logic last_cycle_i,
    input wire logic blocking_instr_i,
    input wire logic return_from_interrupt_i,
    output logic call_active_o,
    output logic push_pc_o,
    output logic load_pc_o,
    output tsic_pkg::tsic_vec_t vector_o,
    output tsic_pkg::tsic_src_t source_o,
    output logic power_fail_irq_o
);
    import tsic_pkg::*;

    tsic_res_if rif ();

    tsic_resolver u_res (
        .rif(rif.res)
    );

    logic [1:0] phase;
    logic c3;
    logic [`TSIC_NPIN-1:0] pin_fall;
    logic [`TSIC_NPIN-1:0] pin_low;

    // Machine cycle of four clocks, phase C3 is the sample point
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            phase <= '0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign c3 = (phase == `TSIC_PH_C3);

    tsic_pin_sampler u_pins (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(ext_request_pin_i),
        .sample_i(c3),
        .fall_o(pin_fall),
        .low_o(pin_low)
    );

    // Register file
    logic [`TSIC_NSRC:0] enable_reg;
    tsic_mask_t priority_reg;
    logic [`TSIC_NFLAG-1:0] flags;
    logic [`TSIC_NFLAG-1:0] next_flags;
    logic [`TSIC_C_PFEN:0] cfg;
    logic [1:0] in_svc;
    tsic_src_t last_src;
    logic wr_en;
    logic setup;

    function automatic logic reg_hit(logic [7:0] a);
        return a == `TSIC_OFF_EN || a == `TSIC_OFF_PRI || a == `TSIC_OFF_FLAG
            || a == `TSIC_OFF_CFG || a == `TSIC_OFF_STAT;
    endfunction

    assign wr_en = psel_i & penable_i & pwrite_i & reg_hit(paddr_i);
    assign setup = psel_i & ~penable_i;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~reg_hit(paddr_i);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            enable_reg <= '0;
        end else if (wr_en && paddr_i == `TSIC_OFF_EN) begin
            enable_reg <= pwdata_i[`TSIC_NSRC:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            priority_reg <= '0;
        end else if (wr_en && paddr_i == `TSIC_OFF_PRI) begin
            priority_reg <= pwdata_i[`TSIC_NSRC-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg <= '0;
        end else if (wr_en && paddr_i == `TSIC_OFF_CFG) begin
            cfg <= pwdata_i[`TSIC_C_PFEN:0];
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_o <= `TSIC_RST_REG;
        end else if (setup) begin
            unique case (paddr_i)
                `TSIC_OFF_EN: prdata_o <= 32'(enable_reg);
                `TSIC_OFF_PRI: prdata_o <= 32'(priority_reg);
                `TSIC_OFF_FLAG: prdata_o <= 32'(flags);
                `TSIC_OFF_CFG: prdata_o <= 32'(cfg);
                `TSIC_OFF_STAT: prdata_o <= 32'({power_fail_irq_o, last_src,
                    call_active_o, in_svc});
                default: prdata_o <= `TSIC_RST_REG;
            endcase
        end
    end

    // Request gating and polling
    tsic_mask_t src_raw;
    logic call_start;
    tsic_call_e state;
    logic [4:0] call_cnt;

    assign src_raw = {flags[`TSIC_F_WATCHDOG_REQUEST_FLAG],
        flags[`TSIC_F_EXT5:`TSIC_F_EXT2],
        flags[`TSIC_F_RI1] | flags[`TSIC_F_TI1],
        flags[`TSIC_F_TF2] | flags[`TSIC_F_TIMER2_CAPTURE_RELOAD_FLAG],
        flags[`TSIC_F_RI0] | flags[`TSIC_F_TI0],
        flags[`TSIC_F_TF1], flags[`TSIC_F_EXT1],
        flags[`TSIC_F_TF0], flags[`TSIC_F_EXT0]};

    assign rif.req = src_raw & enable_reg[`TSIC_NSRC-1:0]
        & {`TSIC_NSRC{enable_reg[`TSIC_EN_GLOBAL]}};
    assign rif.hi = priority_reg;
    assign rif.in_svc = in_svc;

    // Fresh decision each poll; nothing pending is stored
    assign call_start = c3 & (state == TSIC_IDLE) & rif.grant
        & last_cycle_i & ~blocking_instr_i;

    function automatic logic [`TSIC_NFLAG-1:0] hw_clr(tsic_src_t idx,
            logic [`TSIC_C_PFEN:0] c);
        logic [`TSIC_NFLAG-1:0] m;
        m = '0;
        case (idx)
            `TSIC_S_EXT0: m[`TSIC_F_EXT0] = c[`TSIC_C_TRIG0];
            `TSIC_S_TF0: m[`TSIC_F_TF0] = 1'b1;
            `TSIC_S_EXT1: m[`TSIC_F_EXT1] = c[`TSIC_C_TRIG1];
            `TSIC_S_TF1: m[`TSIC_F_TF1] = 1'b1;
            default: begin
                if (idx >= `TSIC_S_EXT2 && idx <= `TSIC_S_EXT5) begin
                    m[`TSIC_F_EXT2 + int'(idx - `TSIC_S_EXT2)] =
                        c[`TSIC_C_HC2 + int'(idx - `TSIC_S_EXT2)];
                end
            end
        endcase
        return m;
    endfunction

    // Flags: software write, call clear, then hardware set wins
    logic [`TSIC_NFLAG-1:0] set_mask;
    logic [1:0] lvl;

    always_comb begin
        set_mask = '0;
        lvl = ~cfg[`TSIC_C_TRIG1:`TSIC_C_TRIG0];
        set_mask[`TSIC_F_EXT0] = c3 & (lvl[0] ? pin_low[0] : pin_fall[0]);
        set_mask[`TSIC_F_EXT1] = c3 & (lvl[1] ? pin_low[1] : pin_fall[1]);
        set_mask[`TSIC_F_EXT5:`TSIC_F_EXT2] =
            pin_fall[`TSIC_NPIN-1:2];
        set_mask[`TSIC_F_TF0] = timer0_overflow_i;
        set_mask[`TSIC_F_TF1] = timer1_overflow_i;
        set_mask[`TSIC_F_TF2] = timer2_overflow_i;
        set_mask[`TSIC_F_TIMER2_CAPTURE_RELOAD_FLAG] = timer2_capture_reload_i;
        set_mask[`TSIC_F_RI0] = serial0_rx_done_i;
        set_mask[`TSIC_F_TI0] = serial0_tx_done_i;
        set_mask[`TSIC_F_RI1] = serial1_rx_done_i;
        set_mask[`TSIC_F_TI1] = serial1_tx_done_i;
        set_mask[`TSIC_F_WATCHDOG_REQUEST_FLAG] = watchdog_timeout_i;
    end

    always_comb begin
        next_flags = flags;
        if (wr_en && paddr_i == `TSIC_OFF_FLAG) begin
            next_flags = pwdata_i[`TSIC_NFLAG-1:0];
        end
        if (call_start) begin
            next_flags = next_flags & ~hw_clr(rif.win, cfg);
        end
        // Level mode flag tracks the sampled pin
        if (c3 && lvl[0] && !pin_low[0]) begin
            next_flags[`TSIC_F_EXT0] = 1'b0;
        end
        if (c3 && lvl[1] && !pin_low[1]) begin
            next_flags[`TSIC_F_EXT1] = 1'b0;
        end
        next_flags = next_flags | set_mask;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // Hardware call sequencer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= TSIC_IDLE;
            call_cnt <= '0;
        end else begin
            unique case (state)
                TSIC_IDLE: begin
                    call_cnt <= '0;
                    if (call_start) begin
                        state <= TSIC_CALL;
                    end
                end
                TSIC_CALL: begin
                    call_cnt <= call_cnt + 5'h1;
                    if (call_cnt == `TSIC_CALL_LAST) begin
                        state <= TSIC_IDLE;
                    end
                end
            endcase
        end
    end

    assign call_active_o = (state == TSIC_CALL);

    // Core pushes the PC only; status word is left alone
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            push_pc_o <= 1'b0;
            load_pc_o <= 1'b0;
        end else begin
            push_pc_o <= call_start;
            load_pc_o <= (state == TSIC_CALL) && call_cnt == `TSIC_CALL_LAST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            vector_o <= '0;
            source_o <= '0;
            last_src <= '0;
        end else if (call_start) begin
            vector_o <= tsic_vector(rif.win);
            source_o <= rif.win;
            last_src <= rif.win;
        end
    end

    // In-service bits; a call sets, return-from-interrupt clears
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            in_svc <= '0;
        end else if (call_start) begin
            in_svc[rif.win_hi] <= 1'b1;
        end else if (return_from_interrupt_i) begin
            if (in_svc[1]) begin
                in_svc[1] <= 1'b0;
            end else begin
                in_svc[0] <= 1'b0;
            end
        end
    end

    // Power-fail ignores the global enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            power_fail_irq_o <= 1'b0;
        end else begin
            power_fail_irq_o <= power_fail_i & cfg[`TSIC_C_PFEN];
        end
    end

    glob_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !enable_reg[`TSIC_EN_GLOBAL] |-> !call_start)
        else $error("call started with global enable clear");

    poll_point_a: assert property (@(posedge clk_i) disable iff (srst_i)
        call_start |-> c3 && last_cycle_i && !blocking_instr_i)
        else $error("call outside last cycle poll");

    call_len_a: assert property (@(posedge clk_i) disable iff (srst_i)
        call_start |=> call_active_o[*8] ##1 call_active_o[*8] ##1 load_pc_o)
        else $error("call sequence not four machine cycles");

    vec_map_a: assert property (@(posedge clk_i) disable iff (srst_i)
        call_start && rif.win == `TSIC_S_EXT2 |=> vector_o == 16'h0043)
        else $error("external 2 vector wrong");

    svc_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
        call_start && rif.win_hi |=> in_svc[1])
        else $error("high in-service not set");

    return_from_interrupt_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        return_from_interrupt_i && !call_start && in_svc == 2'h3 |=> in_svc == 2'h1)
        else $error("return did not clear highest level");

    tf0_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        call_start && rif.win == `TSIC_S_TF0 && !timer0_overflow_i
        |=> !flags[`TSIC_F_TF0])
        else $error("timer 0 flag not cleared by call");

    t2_keep_a: assert property (@(posedge clk_i) disable iff (srst_i)
        call_start && rif.win == 4'h5 && !wr_en
        && !timer2_overflow_i && !timer2_capture_reload_i
        |=> $stable(flags[`TSIC_F_TIMER2_CAPTURE_RELOAD_FLAG:`TSIC_F_TF2]))
        else $error("timer 2 flags changed by call");

    edge_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
        c3 && pin_fall[2] |=> flags[`TSIC_F_EXT2])
        else $error("falling edge did not set flag");

    no_preempt_a: assert property (@(posedge clk_i) disable iff (srst_i)
        in_svc[1] |-> !call_start)
        else $error("call preempted a high level routine");
endmodule

// *** tb/tsic_core_model.sv ***
/* Core sequencer stand-in: ends instructions, flags blocking ones,
   returns from service, keeps program counter and stack.
   Assumes one clock shared with the controller. */
`timescale 1ns/10ps
module tsic_core_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic push_pc_i,
    input wire logic load_pc_i,
    input wire tsic_pkg::tsic_vec_t vector_i,
    input wire logic slow_i,
    input wire logic block_i,
    input wire logic return_from_interrupt_req_i,
    output logic last_cycle_o,
    output logic blocking_o,
    output logic return_from_interrupt_o,
    output tsic_pkg::tsic_vec_t pc_o,
    output logic [4:0] span_o
);
    import tsic_pkg::*;
    logic [2:0] phase;
    logic [4:0] run;
    tsic_vec_t stack[$];
    // Slow: two-machine-cycle instructions
    assign last_cycle_o = !slow_i || phase[2];
    assign blocking_o = block_i;
    always @(posedge clk_i) begin
        if (srst_i) begin
            phase <= 3'h0;
            pc_o <= 16'h0100;
            return_from_interrupt_o <= 1'b0;
            span_o <= 5'h00;
            run <= 5'h00;
            stack.delete();
        end else begin
            phase <= phase + 3'h1;
            run <= push_pc_i ? 5'h00 : run + 5'h01;
            return_from_interrupt_o <= return_from_interrupt_req_i;
            if (push_pc_i) begin
                stack.push_back(pc_o);
            end
            if (load_pc_i) begin
                pc_o <= vector_i;
                span_o <= run + 5'h01;
            end
            if (return_from_interrupt_o && stack.size() > 0) begin
                pc_o <= stack.pop_back();
            end
        end
    end
endmodule

// *** tb/twelve_source_interrupt_controller_bench.sv ***
/* Self-checking bench of the interrupt controller: registers, vectors,
   flag clearing, priority, gating, pins and core handshake.
   Assumes the design files and the core model are compiled first. */
`timescale 1ns/10ps
module twelve_source_interrupt_controller_bench;
    import tsic_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] pins = 6'h3F;
    logic [8:0] hw = 9'h000;
    logic power_fail = 1'b0;
    logic slow = 1'b0;
    logic block = 1'b0;
    logic return_from_interrupt_req = 1'b0;
    logic [31:0] prdata, rd, f;
    logic pready, pslverr, err, last_cycle, blocking, return_from_interrupt, load_pc, push_pc, pf_irq, clr;
    tsic_vec_t pc, vec;
    logic act;
    tsic_src_t source;
    logic [4:0] span;
    logic [3:0] hc;
    logic [11:0] pri, m;
    int i, j, error_cnt = 0, n_compared = 0;
    logic [15:0] vtab [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
        16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};
    int fbit [12] = '{0, 1, 2, 3, 5, 7, 9, 10, 11, 12, 13, 14};
    int hbit [9] = '{1, 3, 6, 7, 14, 4, 5, 8, 9};

    tsic_top dut_u (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .ext_request_pin_i(pins),
        .timer0_overflow_i(hw[0]),
        .timer1_overflow_i(hw[1]),
        .timer2_overflow_i(hw[2]),
        .timer2_capture_reload_i(hw[3]),
        .watchdog_timeout_i(hw[4]),
        .serial0_rx_done_i(hw[5]),
        .serial0_tx_done_i(hw[6]),
        .serial1_rx_done_i(hw[7]),
        .serial1_tx_done_i(hw[8]),
        .power_fail_i(power_fail),
        .last_cycle_i(last_cycle),
        .blocking_instr_i(blocking),
        .return_from_interrupt_i(return_from_interrupt),
        .call_active_o(act),
        .push_pc_o(push_pc),
        .load_pc_o(load_pc),
        .vector_o(vec),
        .source_o(source),
        .power_fail_irq_o(pf_irq)
    );

    tsic_core_model core_u (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .push_pc_i(push_pc),
        .load_pc_i(load_pc),
        .vector_i(vec),
        .slow_i(slow),
        .block_i(block),
        .return_from_interrupt_req_i(return_from_interrupt_req),
        .last_cycle_o(last_cycle),
        .blocking_o(blocking),
        .return_from_interrupt_o(return_from_interrupt),
        .pc_o(pc),
        .span_o(span)
    );

    always #5 clk_i = !clk_i;

    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            error_cnt++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_call(input logic e, input int s);
        int k;
        int n_act;
        logic seen;
        seen = 1'b0;
        n_act = 0;
        for (k = 0; k < 40 && !seen; k++) begin
            @(posedge clk_i);
            #1;
            seen = (load_pc === 1'b1);
            if (act === 1'b1) n_act++;
        end
        chk(32'(seen), 32'(e));
        chk(32'(n_act), e ? 32'h10 : 32'h0);
        if (seen && e) begin
            chk(32'(source), s);
            @(posedge clk_i);
            #1;
            chk(32'(pc), 32'(vtab[s]));
            chk(32'(span), 32'h10);
        end
    endtask

    task automatic ret();
        @(posedge clk_i);
        return_from_interrupt_req <= 1'b1;
        @(posedge clk_i);
        return_from_interrupt_req <= 1'b0;
    endtask

    function automatic int winner(input logic [11:0] mk, input logic [11:0] p);
        for (int s = 0; s < 12; s++) if (mk[s] && p[s]) return s;
        for (int s = 0; s < 12; s++) if (mk[s]) return s;
        return 0;
    endfunction

    initial begin
        void'($urandom(38543));
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        for (i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
            chk(32'(err), 32'(i == 5));
        end
        hc = 4'($urandom);
        apb(1'b1, 8'h0C, {26'h0, hc, 2'h3});
        apb(1'b1, 8'h00, 32'h00001FFF);
        for (i = 0; i < 12; i++) begin
            slow <= i[0];
            apb(1'b1, 8'h08, 32'h1 << fbit[i]);
            wait_call(1'b1, i);
            apb(1'b0, 8'h08, 32'h0);
            clr = (i < 4) || (i > 6 && i < 11 && hc[i - 7]);
            chk(rd, clr ? 32'h0 : 32'h1 << fbit[i]);
            apb(1'b1, 8'h08, 32'h0);
            ret();
            @(posedge clk_i);
            #1;
            chk(32'(pc), 32'h00000100);
        end
        for (j = 0; j < 6; j++) begin
            pri = 12'($urandom);
            m = 12'($urandom) | 12'h800;
            f = 32'h0;
            for (i = 0; i < 12; i++) begin
                if (m[i]) f |= 32'h1 << fbit[i];
            end
            apb(1'b1, 8'h04, 32'(pri));
            apb(1'b1, 8'h08, f);
            wait_call(1'b1, winner(m, pri));
            apb(1'b1, 8'h08, 32'h0);
            ret();
        end
        apb(1'b1, 8'h04, 32'h00000003);
        apb(1'b1, 8'h08, 32'h00004000);
        wait_call(1'b1, 11);
        apb(1'b1, 8'h08, 32'h00000002);
        wait_call(1'b1, 1);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0000000B);
        apb(1'b1, 8'h08, 32'h00000001);
        wait_call(1'b0, 0);
        ret();
        wait_call(1'b1, 0);
        ret();
        ret();
        apb(1'b1, 8'h04, 32'h0);
        block <= 1'b1;
        apb(1'b1, 8'h08, 32'h00000008);
        wait_call(1'b0, 0);
        apb(1'b1, 8'h08, 32'h0);
        block <= 1'b0;
        wait_call(1'b0, 0);
        apb(1'b1, 8'h00, 32'h00000FFF);
        for (i = 0; i < 9; i++) begin
            @(posedge clk_i);
            hw <= 9'h001 << i;
            @(posedge clk_i);
            hw <= 9'h000;
            wait_call(1'b0, 0);
            apb(1'b0, 8'h08, 32'h0);
            chk(rd, 32'h1 << hbit[i]);
            apb(1'b1, 8'h08, 32'h0);
        end
        apb(1'b1, 8'h0C, 32'h00000043);
        power_fail <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk(32'(pf_irq), 32'h1);
        @(posedge clk_i);
        power_fail <= 1'b0;
        apb(1'b1, 8'h00, 32'h00001000);
        chk(32'(pf_irq), 32'h0);
        pins <= 6'h3B;
        repeat (12) @(posedge clk_i);
        wait_call(1'b0, 0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h00000400);
        pins <= 6'h3F;
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h0C, 32'h00000002);
        apb(1'b1, 8'h00, 32'h00001001);
        pins <= 6'h3E;
        wait_call(1'b1, 0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h1);
        pins <= 6'h3F;
        repeat (12) @(posedge clk_i);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        ret();
        test_done();
    end
endmodule
